// >>> src/mhrp_port.sv
// Host register and message buffer port of the media access controller.
// Assumes the transmit, receive and management engines sit on ref_clk and
// talk to this block through the plain engine-side ports below.
`timescale 1ns/100ps
`default_nettype none
// Function
// - Transmit length: 11 bits, split over two bytes
// - Length pair: write transmit, read receive
// - Receive length excludes preamble, delimiter, checksum
// - Receive length upper byte bits 7..3 zero
// - Management data pair: write outgoing, read received
// - Interrupt enable resets zero; tx, rx, mgmt bits
// - Interrupt enable unused bits read zero
// - PHY address five bits, resets to one
// - Register index five bits, resets to zero
// - Command writes ignored while action pending
// - Command bit1 reads, bit0 writes, rest zero
// - Host supplies header and data only
// - Transmit buffer: byte write, nibble read
// - Receive buffer: nibble write, byte read
// - Write strobe updates addressed location
// - Read strobe presents addressed contents
// - Status read or reset clears interrupt flags
module mhrp_port
	import mhrp_pkg::*;
#(
	parameter logic MGMT_PRESENT = 1'b1
) (
	input wire logic ref_clk, // System clock.
	input wire logic rst_b, // Synchronous reset, active low.
	input wire logic [ADDR_W-1:0] host_addr, // Host address.
	input wire logic [7:0] host_write_bus, // Host write data.
	input wire logic host_wr, // Host write strobe.
	input wire logic host_rd, // Host read strobe.
	output logic [7:0] host_read_bus, // Host read data.
	output logic irq, // Interrupt to host.
	input wire logic [7:0] status_byte, // Status value from engines.
	input wire logic tx_done_evt, // Transmitter finished a frame.
	input wire logic rx_done_evt, // Receiver finished a valid frame.
	input wire logic mgmt_done_evt, // Management action finished.
	output logic [LEN_W-1:0] transmit_length, // Bytes to send.
	input wire logic [NIB_ADDR_W-1:0] tx_nib_addr, // Transmit nibble addr.
	output logic [3:0] tx_nib_data, // Transmit nibble, one cycle late.
	input wire logic [LEN_W-1:0] rx_frame_len, // Received byte count.
	input wire logic rx_nib_valid, // Receive nibble offered.
	output logic rx_nib_ready, // Receive nibble accepted.
	input wire logic [NIB_ADDR_W-1:0] rx_nib_addr, // Receive nibble addr.
	input wire logic [3:0] rx_nib_data, // Receive nibble.
	output logic [4:0] phy_device_address, // PHY address.
	output logic [4:0] phy_register_index, // PHY register index.
	output logic [15:0] mgmt_write_value, // Outgoing PHY value.
	input wire logic [15:0] mgmt_rx_value, // Value read from the PHY.
	output logic mgmt_start_rd, // Pulse: start PHY read.
	output logic mgmt_start_wr // Pulse: start PHY write.
);
	logic [7:0] tx_mem_r [2048];
	logic [3:0] rx_lo_r [2048];
	logic [3:0] rx_hi_r [2048];

	logic [LEN_W-1:0] transmit_length_r;
	logic [LEN_W-1:0] receive_length_r;
	logic [4:0] phy_device_address_r;
	logic [4:0] reg_index_r;
	logic [15:0] wr_value_r;
	logic [15:0] rd_value_r;
	logic [1:0] cmd_r;
	logic [1:0] cmd_nxt;
	logic [2:0] ie_r;
	logic [2:0] flag_r;
	logic [2:0] flag_nxt;
	logic irq_r;
	logic start_rd_r;
	logic start_wr_r;
	logic [7:0] host_rdata_r;
	logic [7:0] reg_rdata_r;
	logic [7:0] rxbuf_rdata_r;
	mhrp_rsel_t rsel_r;
	logic [3:0] tx_nib_r;
	logic rx_done_d_r;
	logic mgmt_done_d_r;

	// Host- and engine-side outputs straight from registers.
	assign host_read_bus = host_rdata_r;
	assign irq = irq_r;
	assign transmit_length = transmit_length_r;
	assign tx_nib_data = tx_nib_r;
	assign phy_device_address = phy_device_address_r;
	assign phy_register_index = reg_index_r;
	assign mgmt_write_value = wr_value_r;
	assign mgmt_start_rd = start_rd_r;
	assign mgmt_start_wr = start_wr_r;

	// Address decode.
	wire logic in_buf = (host_addr <= BUF_LAST);
	wire logic wr_buf = host_wr && in_buf;
	wire logic wr_phy_device_address = host_wr && (host_addr == OFS_PHY_DEVICE_ADDRESS);
	wire logic wr_reg_index = host_wr && (host_addr == OFS_REG_INDEX);
	wire logic wr_data_hi = host_wr && (host_addr == OFS_DATA_HI);
	wire logic wr_data_lo = host_wr && (host_addr == OFS_DATA_LO);
	wire logic wr_cmd = host_wr && (host_addr == OFS_MGMT_CMD);
	wire logic wr_ie = host_wr && (host_addr == OFS_IRQ_EN);
	wire logic wr_len_hi = host_wr && (host_addr == OFS_LEN_HI);
	wire logic wr_len_lo = host_wr && (host_addr == OFS_LEN_LO);
	wire logic rd_status = host_rd && (host_addr == OFS_STATUS);

	// Pending is a latched command not yet retired by the engine.
	wire logic mgmt_pending = (cmd_r != RST_MGMT_CMD);
	wire logic cmd_take = wr_cmd && !mgmt_pending && MGMT_PRESENT;
	wire logic cmd_rd = host_write_bus[CMD_RD_BIT];
	wire logic cmd_wr = host_write_bus[CMD_WR_BIT] && !cmd_rd;

	// Readable register mux; unused bits are zero.
	wire logic [7:0] len_hi_byte = {5'h00, receive_length_r[10:8]};
	wire logic [7:0] len_lo_byte = receive_length_r[7:0];
	wire logic [7:0] ie_byte = {5'h00, ie_r[2] & MGMT_PRESENT, ie_r[1:0]};
	wire logic [7:0] cmd_byte = {6'h00, cmd_r};
	logic [7:0] reg_mux;

	always_comb begin
		reg_mux = 8'h00;
		unique case (host_addr)
			OFS_PHY_DEVICE_ADDRESS: reg_mux = {3'h0, phy_device_address_r};
			OFS_REG_INDEX: reg_mux = {3'h0, reg_index_r};
			OFS_DATA_HI: reg_mux = rd_value_r[15:8];
			OFS_DATA_LO: reg_mux = rd_value_r[7:0];
			OFS_MGMT_CMD: reg_mux = cmd_byte;
			OFS_IRQ_EN: reg_mux = ie_byte;
			OFS_LEN_HI: reg_mux = len_hi_byte;
			OFS_LEN_LO: reg_mux = len_lo_byte;
			OFS_STATUS: reg_mux = status_byte;
			default: reg_mux = 8'h00;
		endcase
	end

	// Receive nibbles queue here; draining stalls while the host reads
	// the receive buffer so the host port never shares a cycle with it.
	logic [FIFO_WIDTH-1:0] q_out;
	logic q_valid;
	wire logic q_drain = !(host_rd && in_buf);
	wire logic q_pop = q_valid && q_drain;
	wire logic [NIB_ADDR_W-1:0] q_addr = q_out[15:4];
	wire logic [10:0] q_byte = q_addr[11:1];

	mhrp_fifo #(
		.WIDTH(FIFO_WIDTH),
		.DEPTH(FIFO_DEPTH)
	) u_rx_fifo (
		.ref_clk(ref_clk),
		.rst_b(rst_b),
		.in_valid(rx_nib_valid),
		.in_ready(rx_nib_ready),
		.in_data({rx_nib_addr, rx_nib_data}),
		.out_valid(q_valid),
		.out_ready(q_drain),
		.out_data(q_out)
	);

	// Buffers. Low nibble sits at the even nibble address.
	always_ff @(posedge ref_clk) begin
		if (wr_buf) begin
			tx_mem_r[host_addr] <= host_write_bus;
		end
	end

	always_ff @(posedge ref_clk) begin
		if (tx_nib_addr[0]) begin
			tx_nib_r <= tx_mem_r[tx_nib_addr[11:1]][7:4];
		end else begin
			tx_nib_r <= tx_mem_r[tx_nib_addr[11:1]][3:0];
		end
	end

	always_ff @(posedge ref_clk) begin
		if (q_pop && !q_addr[0]) begin
			rx_lo_r[q_byte] <= q_out[3:0];
		end
	end

	always_ff @(posedge ref_clk) begin
		if (q_pop && q_addr[0]) begin
			rx_hi_r[q_byte] <= q_out[3:0];
		end
	end

	always_ff @(posedge ref_clk) begin
		rxbuf_rdata_r <= {rx_hi_r[host_addr], rx_lo_r[host_addr]};
	end

	// Read path: select and data register, then the output register.
	always_ff @(posedge ref_clk) begin
		if (!rst_b) begin
			rsel_r <= MHRP_SEL_NONE;
			reg_rdata_r <= 8'h00;
			host_rdata_r <= 8'h00;
		end else begin
			reg_rdata_r <= reg_mux;
			if (!host_rd) begin
				rsel_r <= MHRP_SEL_NONE;
			end else if (in_buf) begin
				rsel_r <= MHRP_SEL_RXBUF;
			end else begin
				rsel_r <= MHRP_SEL_REG;
			end
			unique case (rsel_r)
				MHRP_SEL_REG: host_rdata_r <= reg_rdata_r;
				MHRP_SEL_RXBUF: host_rdata_r <= rxbuf_rdata_r;
				MHRP_SEL_NONE: host_rdata_r <= host_rdata_r;
				default: host_rdata_r <= 8'h00;
			endcase
		end
	end

	// Host-written configuration.
	always_ff @(posedge ref_clk) begin
		if (!rst_b) begin
			phy_device_address_r <= RST_PHY_DEVICE_ADDRESS;
			reg_index_r <= RST_REG_INDEX;
			ie_r <= RST_IRQ_EN;
		end else begin
			if (wr_phy_device_address) begin
				phy_device_address_r <= host_write_bus[4:0];
			end
			if (wr_reg_index) begin
				reg_index_r <= host_write_bus[4:0];
			end
			if (wr_ie) begin
				ie_r <= host_write_bus[2:0];
			end
		end
	end

	// Length pair: writes land in transmit, reads see receive.
	always_ff @(posedge ref_clk) begin
		if (!rst_b) begin
			transmit_length_r <= RST_LENGTH;
		end else begin
			if (wr_len_hi) begin
				transmit_length_r[10:8] <= host_write_bus[2:0];
			end
			if (wr_len_lo) begin
				transmit_length_r[7:0] <= host_write_bus;
			end
		end
	end

	// The receiver's count already excludes preamble, delimiter and
	// checksum; it is captured when the frame completes and capped.
	always_ff @(posedge ref_clk) begin
		if (!rst_b) begin
			receive_length_r <= RST_LENGTH;
		end else if (rx_done_evt) begin
			if (rx_frame_len > MAX_LENGTH) begin
				receive_length_r <= MAX_LENGTH;
			end else begin
				receive_length_r <= rx_frame_len;
			end
		end
	end

	// Management data pair; the lower address carries the high byte.
	always_ff @(posedge ref_clk) begin
		if (!rst_b) begin
			wr_value_r <= RST_MGMT_DATA;
			rd_value_r <= RST_MGMT_DATA;
			mgmt_done_d_r <= 1'b0;
		end else begin
			mgmt_done_d_r <= mgmt_done_evt;
			if (wr_data_hi) begin
				wr_value_r[15:8] <= host_write_bus;
			end
			if (wr_data_lo) begin
				wr_value_r[7:0] <= host_write_bus;
			end
			if (mgmt_done_evt && cmd_r[CMD_RD_BIT]) begin
				rd_value_r <= mgmt_rx_value;
			end
		end
	end

	// Command register: taken only when idle, retired by the engine.
	always_comb begin
		cmd_nxt = cmd_r;
		if (mgmt_done_evt) begin
			cmd_nxt = RST_MGMT_CMD;
		end else if (cmd_take) begin
			cmd_nxt = {cmd_rd, cmd_wr};
		end
	end

	always_ff @(posedge ref_clk) begin
		if (!rst_b) begin
			cmd_r <= RST_MGMT_CMD;
			start_rd_r <= 1'b0;
			start_wr_r <= 1'b0;
		end else begin
			cmd_r <= cmd_nxt;
			start_rd_r <= cmd_take && cmd_rd;
			start_wr_r <= cmd_take && cmd_wr;
		end
	end

	// Sticky flags; a new event wins over the status-read clear.
	wire logic [2:0] flag_set = {
		mgmt_done_evt & ie_r[IE_MD_BIT] & MGMT_PRESENT,
		rx_done_evt & ie_r[IE_RX_BIT],
		tx_done_evt & ie_r[IE_TX_BIT]
	};

	always_comb begin
		flag_nxt = flag_r;
		if (rd_status) begin
			flag_nxt = 3'h0;
		end
		flag_nxt = flag_nxt | flag_set;
	end

	always_ff @(posedge ref_clk) begin
		if (!rst_b) begin
			flag_r <= 3'h0;
			irq_r <= 1'b0;
			rx_done_d_r <= 1'b0;
		end else begin
			flag_r <= flag_nxt;
			irq_r <= |flag_nxt;
			rx_done_d_r <= rx_done_evt;
		end
	end
endmodule
`default_nettype wire

// >>> pkg/mhrp_pkg.sv
// Constants for the host register port of the 10/100 media access controller.
// Assumes one 250 MHz clock domain shared by the host bus and the engines.
package mhrp_pkg;
	localparam int ADDR_W = 11;
	localparam int NIB_ADDR_W = 12;
	localparam int LEN_W = 11;
	localparam int FIFO_DEPTH = 16;
	localparam int FIFO_WIDTH = 16;
	localparam logic [10:0] BUF_LAST = 11'h5ed;
	localparam logic [10:0] OFS_PHY_DEVICE_ADDRESS = 11'h5f0;
	localparam logic [10:0] OFS_REG_INDEX = 11'h5f1;
	localparam logic [10:0] OFS_DATA_HI = 11'h5f2;
	localparam logic [10:0] OFS_DATA_LO = 11'h5f3;
	localparam logic [10:0] OFS_MGMT_CMD = 11'h5f4;
	localparam logic [10:0] OFS_IRQ_EN = 11'h5f5;
	localparam logic [10:0] OFS_LEN_HI = 11'h5f6;
	localparam logic [10:0] OFS_LEN_LO = 11'h5f7;
	localparam logic [10:0] OFS_STATUS = 11'h5f9;
	localparam logic [4:0] RST_PHY_DEVICE_ADDRESS = 5'h01;
	localparam logic [4:0] RST_REG_INDEX = 5'h00;
	localparam logic [15:0] RST_MGMT_DATA = 16'h0000;
	localparam logic [1:0] RST_MGMT_CMD = 2'h0;
	localparam logic [2:0] RST_IRQ_EN = 3'h0;
	localparam logic [10:0] RST_LENGTH = 11'h000;
	localparam logic [10:0] MAX_LENGTH = 11'h5ea;
	localparam int CMD_WR_BIT = 0;
	localparam int CMD_RD_BIT = 1;
	localparam int IE_TX_BIT = 0;
	localparam int IE_RX_BIT = 1;
	localparam int IE_MD_BIT = 2;
	typedef enum logic [1:0] {
		MHRP_SEL_NONE = 2'b00,
		MHRP_SEL_REG = 2'b01,
		MHRP_SEL_RXBUF = 2'b10
	} mhrp_rsel_t;
endpackage

// >>> src/mhrp_fifo.sv
// Synchronous FIFO with valid and ready on both sides.
// Assumes both sides run on the same clock; flags come from registers.
`timescale 1ns/100ps
`default_nettype none
module mhrp_fifo
	import mhrp_pkg::*;
#(
	parameter int WIDTH = FIFO_WIDTH,
	parameter int DEPTH = FIFO_DEPTH
) (
	input wire logic ref_clk, // System clock.
	input wire logic rst_b, // Synchronous reset, active low.
	input wire logic in_valid, // Word offered.
	output logic in_ready, // Room for a word.
	input wire logic [WIDTH-1:0] in_data, // Word written.
	output logic out_valid, // Word available.
	input wire logic out_ready, // Drain takes the word.
	output logic [WIDTH-1:0] out_data // Oldest word.
);
	localparam int AW = $clog2(DEPTH);
	localparam logic [AW:0] DEPTH_CNT = (AW+1)'(DEPTH);
	logic [WIDTH-1:0] mem_r [DEPTH];
	logic [AW-1:0] wr_ptr_r;
	logic [AW-1:0] rd_ptr_r;
	logic [AW:0] count_r;
	logic [AW:0] count_nxt;
	logic full_r;
	logic empty_r;
	logic space_r;
	wire logic push = in_valid && !full_r;
	wire logic pop = out_ready && !empty_r;

	assign in_ready = space_r;
	assign out_valid = !empty_r;
	assign out_data = mem_r[rd_ptr_r];

	always_comb begin
		count_nxt = count_r;
		if (push && !pop) begin
			count_nxt = count_r + 1'b1;
		end else if (pop && !push) begin
			count_nxt = count_r - 1'b1;
		end
	end

	always_ff @(posedge ref_clk) begin
		if (push) begin
			mem_r[wr_ptr_r] <= in_data;
		end
	end

	always_ff @(posedge ref_clk) begin
		if (!rst_b) begin
			wr_ptr_r <= '0;
			rd_ptr_r <= '0;
			count_r <= '0;
			full_r <= 1'b0;
			empty_r <= 1'b1;
			space_r <= 1'b1;
		end else begin
			if (push) begin
				wr_ptr_r <= wr_ptr_r + 1'b1;
			end
			if (pop) begin
				rd_ptr_r <= rd_ptr_r + 1'b1;
			end
			count_r <= count_nxt;
			full_r <= (count_nxt == DEPTH_CNT);
			space_r <= (count_nxt != DEPTH_CNT);
			empty_r <= (count_nxt == '0);
		end
	end
endmodule
`default_nettype wire

// >>> test/mhrp_port_monitor.sv
// Concurrent checks on the host side of the register port.
// Assumes one clock, ref_clk, and a synchronous active-low reset, rst_b.
`timescale 1ns/100ps
`default_nettype none
module mhrp_port_monitor
	import mhrp_pkg::*;
(
	input wire logic ref_clk, // System clock.
	input wire logic rst_b, // Reset, active low.
	input wire logic [ADDR_W-1:0] host_addr, // Host address.
	input wire logic [7:0] host_write_bus, // Host write data.
	input wire logic host_wr, // Write strobe.
	input wire logic host_rd, // Read strobe.
	input wire logic [7:0] host_read_bus, // Read data.
	input wire logic irq, // Interrupt.
	input wire logic tx_done_evt, // Transmit done.
	input wire logic rx_done_evt, // Receive done.
	input wire logic mgmt_done_evt, // Management done.
	input wire logic [LEN_W-1:0] transmit_length, // Transmit length.
	input wire logic [4:0] phy_device_address, // PHY address.
	input wire logic [15:0] mgmt_write_value, // Outgoing value.
	input wire logic mgmt_start_rd, // Read start pulse.
	input wire logic mgmt_start_wr // Write start pulse.
);
	logic busy_r;
	wire logic any_evt = tx_done_evt || rx_done_evt || mgmt_done_evt;
	wire logic cmd_wr = host_wr && host_addr == OFS_MGMT_CMD;
	wire logic idle = !busy_r && !mgmt_start_rd && !mgmt_start_wr;
	wire logic busy_nxt = (busy_r || mgmt_start_rd || mgmt_start_wr) &&
		!mgmt_done_evt;
	// Tracks a started management action until the engine retires it.
	always_ff @(posedge ref_clk) begin
		busy_r <= rst_b ? busy_nxt : 1'b0;
	end
	default clocking cb @(posedge ref_clk); endclocking
	default disable iff (!rst_b);
	sequence s_take_rd;
		cmd_wr && idle && host_write_bus[1];
	endsequence
	sequence s_take_wr;
		cmd_wr && idle && host_write_bus[1:0] == 2'b01;
	endsequence
	sequence s_stat_rd;
		host_rd && host_addr == OFS_STATUS && !any_evt ##1 !any_evt;
	endsequence
	property p_cmd_rd;
		s_take_rd |=> mgmt_start_rd && !mgmt_start_wr ##1 !mgmt_start_rd;
	endproperty
	a_cmd_rd: assert property (p_cmd_rd) else $error("read start wrong");
	property p_cmd_wr;
		s_take_wr |=> mgmt_start_wr && !mgmt_start_rd;
	endproperty
	a_cmd_wr: assert property (p_cmd_wr) else $error("write start wrong");
	property p_cmd_busy;
		cmd_wr && busy_r |=> !mgmt_start_rd && !mgmt_start_wr;
	endproperty
	a_cmd_busy: assert property (p_cmd_busy) else $error("busy cmd taken");
	property p_phy_rd;
		host_rd && !host_wr && host_addr == OFS_PHY_DEVICE_ADDRESS |->
			##2 host_read_bus == {3'h0, $past(phy_device_address, 2)};
	endproperty
	a_phy_rd: assert property (p_phy_rd) else $error("PHY address read");
	property p_len_hi_rd;
		host_rd && host_addr == OFS_LEN_HI |-> ##2 host_read_bus[7:3] == 5'h00;
	endproperty
	a_len_hi_rd: assert property (p_len_hi_rd) else $error("length bits");
	property p_len_lo_wr;
		host_wr && host_addr == OFS_LEN_LO |=>
			transmit_length[7:0] == $past(host_write_bus);
	endproperty
	a_len_lo_wr: assert property (p_len_lo_wr) else $error("length low");
	property p_len_hi_wr;
		host_wr && host_addr == OFS_LEN_HI |=>
			transmit_length[10:8] == $past(host_write_bus[2:0]);
	endproperty
	a_len_hi_wr: assert property (p_len_hi_wr) else $error("length high");
	property p_data_hi;
		host_wr && host_addr == OFS_DATA_HI |=>
			mgmt_write_value[15:8] == $past(host_write_bus);
	endproperty
	a_data_hi: assert property (p_data_hi) else $error("data high byte");
	property p_irq_clr;
		s_stat_rd |=> !irq;
	endproperty
	a_irq_clr: assert property (p_irq_clr) else $error("irq not cleared");
	property p_irq_src;
		$rose(irq) |-> $past(any_evt);
	endproperty
	a_irq_src: assert property (p_irq_src) else $error("irq without event");
endmodule
bind mhrp_port mhrp_port_monitor u_mon (.ref_clk(ref_clk), .rst_b(rst_b),
	.host_addr(host_addr), .host_write_bus(host_write_bus),
	.host_wr(host_wr), .host_rd(host_rd), .host_read_bus(host_read_bus),
	.irq(irq), .tx_done_evt(tx_done_evt), .rx_done_evt(rx_done_evt),
	.mgmt_done_evt(mgmt_done_evt), .transmit_length(transmit_length),
	.phy_device_address(phy_device_address),
	.mgmt_write_value(mgmt_write_value), .mgmt_start_rd(mgmt_start_rd),
	.mgmt_start_wr(mgmt_start_wr));
`default_nettype wire

// >>> test/mhrp_host_model.sv
// Host processor model on the parallel register bus.
// Assumes read data shows two edges after the strobe is taken.
`timescale 1ns/100ps
`default_nettype none
module mhrp_host_model
	import mhrp_pkg::*;
(
	input wire logic ref_clk, // System clock.
	input wire logic [7:0] host_read_bus, // Read data.
	output logic [ADDR_W-1:0] host_addr, // Address.
	output logic [7:0] host_write_bus, // Write data.
	output logic host_wr, // Write strobe.
	output logic host_rd // Read strobe.
);
	initial begin
		host_addr = '0;
		host_write_bus = '0;
		host_wr = 1'b0;
		host_rd = 1'b0;
	end
	// Released lines are inverted so a stale value is never mistaken.
	task automatic wr(input logic [10:0] a, input logic [7:0] v);
		@(posedge ref_clk);
		host_addr <= a;
		host_write_bus <= v;
		host_wr <= 1'b1;
		@(posedge ref_clk);
		host_wr <= 1'b0;
		host_addr <= ~a;
		host_write_bus <= ~v;
	endtask
	task automatic rd(input logic [10:0] a, input int n, output logic [7:0] v);
		@(posedge ref_clk);
		host_addr <= a;
		host_rd <= 1'b1;
		repeat (n) @(posedge ref_clk);
		host_rd <= 1'b0;
		host_addr <= ~a;
		repeat (2) @(posedge ref_clk);
		#1 v = host_read_bus;
	endtask
endmodule
`default_nettype wire

// >>> test/mac_host_register_port_tb.sv
// Self-checking bench for the host register port.
// Assumes the host model drives the bus and this bench drives the engines.
`timescale 1ns/100ps
`default_nettype none
`define CHK(g, e) begin \
	n_checks++; \
	if ((g) !== (e)) begin \
		fail_count++; \
		$display("BAD %0t got %h want %h", $time, (g), (e)); \
	end \
end
module mac_host_register_port_tb
	import mhrp_pkg::*;
;
	logic ref_clk, rst_b, host_wr, host_rd, irq, tx_done_evt, rx_done_evt;
	logic mgmt_done_evt, rx_nib_valid, rx_nib_ready, mgmt_start_rd;
	logic mgmt_start_wr;
	logic [10:0] host_addr, transmit_length, rx_frame_len;
	logic [7:0] host_write_bus, host_read_bus, status_byte, d;
	logic [11:0] tx_nib_addr, rx_nib_addr;
	logic [3:0] tx_nib_data, rx_nib_data;
	logic [4:0] phy_device_address, phy_register_index;
	logic [15:0] mgmt_write_value, mgmt_rx_value;
	int fail_count, n_checks, cyc, n_rd, n_wr;
	mhrp_port dut (.ref_clk(ref_clk), .rst_b(rst_b), .host_addr(host_addr),
		.host_write_bus(host_write_bus), .host_wr(host_wr), .host_rd(host_rd),
		.host_read_bus(host_read_bus), .irq(irq), .status_byte(status_byte),
		.tx_done_evt(tx_done_evt), .rx_done_evt(rx_done_evt),
		.mgmt_done_evt(mgmt_done_evt), .transmit_length(transmit_length),
		.tx_nib_addr(tx_nib_addr), .tx_nib_data(tx_nib_data),
		.rx_frame_len(rx_frame_len), .rx_nib_valid(rx_nib_valid),
		.rx_nib_ready(rx_nib_ready), .rx_nib_addr(rx_nib_addr),
		.rx_nib_data(rx_nib_data), .phy_device_address(phy_device_address),
		.phy_register_index(phy_register_index),
		.mgmt_write_value(mgmt_write_value), .mgmt_rx_value(mgmt_rx_value),
		.mgmt_start_rd(mgmt_start_rd), .mgmt_start_wr(mgmt_start_wr));
	mhrp_host_model host (.ref_clk(ref_clk), .host_read_bus(host_read_bus),
		.host_addr(host_addr), .host_write_bus(host_write_bus),
		.host_wr(host_wr), .host_rd(host_rd));
	task automatic close_out();
		$display("checks %0d fails %0d", n_checks, fail_count);
		if (fail_count == 0 && n_checks > 0) begin
			$display("ALL CHECKS OK");
		end else begin
			$display("CHECKS NOT OK");
		end
		$finish;
	endtask
	task automatic rchk(input logic [10:0] a, input logic [7:0] e);
		host.rd(a, 1, d);
		`CHK(d, e)
	endtask
	task automatic ev(input logic [2:0] m);
		@(posedge ref_clk);
		{mgmt_done_evt, rx_done_evt, tx_done_evt} <= m;
		@(posedge ref_clk);
		{mgmt_done_evt, rx_done_evt, tx_done_evt} <= 3'h0;
		@(negedge ref_clk);
	endtask
	task automatic nib(input logic [11:0] a, input logic [3:0] e);
		@(posedge ref_clk);
		tx_nib_addr <= a;
		@(posedge ref_clk);
		@(negedge ref_clk);
		`CHK(tx_nib_data, e)
	endtask
	task automatic t_reset_vals();
		rchk(OFS_PHY_DEVICE_ADDRESS, 8'h01);
		rchk(OFS_REG_INDEX, 8'h00);
		rchk(OFS_IRQ_EN, 8'h00);
		rchk(OFS_MGMT_CMD, 8'h00);
		rchk(OFS_LEN_HI, 8'h00);
		rchk(OFS_DATA_LO, 8'h00);
	endtask
	task automatic t_regs();
		host.wr(OFS_PHY_DEVICE_ADDRESS, 8'hff);
		rchk(OFS_PHY_DEVICE_ADDRESS, 8'h1f);
		`CHK(phy_device_address, 5'h1f)
		host.wr(OFS_REG_INDEX, 8'hea);
		rchk(OFS_REG_INDEX, 8'h0a);
		`CHK(phy_register_index, 5'h0a)
		host.wr(OFS_IRQ_EN, 8'hff);
		rchk(OFS_IRQ_EN, 8'h07);
		host.wr(OFS_IRQ_EN, 8'h00);
		host.wr(11'h5ee, 8'h77);
		rchk(11'h5ee, 8'h00);
	endtask
	task automatic t_len();
		host.wr(OFS_LEN_HI, 8'hff);
		host.wr(OFS_LEN_LO, 8'hea);
		@(negedge ref_clk);
		`CHK(transmit_length, 11'h7ea)
		rchk(OFS_LEN_LO, 8'h00);
		@(posedge ref_clk);
		rx_frame_len <= 11'h5ea;
		ev(3'b010);
		rchk(OFS_LEN_HI, 8'h05);
		rchk(OFS_LEN_LO, 8'hea);
	endtask
	task automatic t_mgmt();
		host.wr(OFS_DATA_HI, 8'h12);
		host.wr(OFS_DATA_LO, 8'h34);
		@(negedge ref_clk);
		`CHK(mgmt_write_value, 16'h1234)
		host.wr(OFS_MGMT_CMD, 8'h03);
		host.wr(OFS_MGMT_CMD, 8'h01);
		rchk(OFS_MGMT_CMD, 8'h02);
		`CHK(n_wr, 0)
		ev(3'b100);
		rchk(OFS_DATA_HI, 8'hbe);
		rchk(OFS_DATA_LO, 8'hef);
		host.wr(OFS_MGMT_CMD, 8'h01);
		rchk(OFS_MGMT_CMD, 8'h01);
		ev(3'b100);
		`CHK(n_rd, 1)
		`CHK(n_wr, 1)
	endtask
	task automatic t_tx();
		host.wr(11'h000, 8'ha5);
		host.wr(BUF_LAST, 8'h3c);
		nib(12'h000, 4'h5);
		nib(12'h001, 4'ha);
		nib({BUF_LAST, 1'b1}, 4'h3);
	endtask
	task automatic t_rx();
		int i;
		logic full;
		i = 0;
		full = 1'b0;
		// A long buffer read stalls the drain so the queue must refuse.
		fork
			host.rd(11'h000, 40, d);
			while (i < 24) begin
				@(posedge ref_clk);
				rx_nib_valid <= 1'b1;
				rx_nib_addr <= 12'(i);
				rx_nib_data <= 4'(i) ^ 4'h9;
				@(negedge ref_clk);
				if (rx_nib_ready) i++;
				else full = 1'b1;
			end
		join
		@(posedge ref_clk);
		rx_nib_valid <= 1'b0;
		`CHK(full, 1'b1)
		repeat (30) @(posedge ref_clk);
		for (int k = 0; k < 12; k++) begin
			rchk(11'(k), {4'(2*k+1) ^ 4'h9, 4'(2*k) ^ 4'h9});
		end
	endtask
	task automatic t_irq();
		host.wr(OFS_IRQ_EN, 8'h01);
		ev(3'b001);
		`CHK(irq, 1'b1)
		rchk(OFS_STATUS, 8'h5a);
		`CHK(irq, 1'b0)
		host.wr(OFS_IRQ_EN, 8'h02);
		ev(3'b001);
		`CHK(irq, 1'b0)
		ev(3'b010);
		`CHK(irq, 1'b1)
		@(posedge ref_clk);
		rst_b <= 1'b0;
		repeat (2) @(posedge ref_clk);
		rst_b <= 1'b1;
		@(negedge ref_clk);
		`CHK(irq, 1'b0)
		rchk(OFS_IRQ_EN, 8'h00);
		rchk(OFS_PHY_DEVICE_ADDRESS, 8'h01);
	endtask
	initial begin
		ref_clk = 1'b0;
		forever #2 ref_clk = ~ref_clk;
	end
	// Counts start pulses and cuts a hung run short.
	always @(posedge ref_clk) begin
		cyc++;
		if (mgmt_start_rd) n_rd++;
		if (mgmt_start_wr) n_wr++;
		if (cyc == 5000) begin
			fail_count++;
			close_out();
		end
	end
	initial begin
		{rst_b, tx_done_evt, rx_done_evt, mgmt_done_evt, rx_nib_valid} = '0;
		{fail_count, n_checks, cyc, n_rd, n_wr} = '0;
		status_byte = 8'h5a;
		rx_frame_len = '0;
		tx_nib_addr = '0;
		rx_nib_addr = '0;
		rx_nib_data = '0;
		mgmt_rx_value = 16'hbeef;
		repeat (6) @(posedge ref_clk);
		rst_b <= 1'b1;
		t_reset_vals();
		t_regs();
		t_len();
		t_mgmt();
		t_tx();
		t_rx();
		t_irq();
		close_out();
	end
endmodule
`default_nettype wire
